// *** core/unfde_pkg.sv ***
// Purpose: shared constants, states and carriers of the nine-bit uart with driver enable
// Assumes: 50 MHz system clock, 16x oversampling of every bit
// Notes: no register map; configuration and status travel as packed structs

// ==========================================================
// package
package unfde_pkg;
	// clock rate of the system clock in hertz
	localparam int unsigned CLK_HZ = 50_000_000;
	// oversampling ticks per bit, last tick index and receiver mid point
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] RX_MID_TICK = 4'h7;
	// ticks from a write to the start bit: one bit plus one tick of phase slack
	localparam logic [4:0] DRV_SETUP_TICKS = 5'h11;
	// index of the last data bit, lsb first
	localparam logic [2:0] DATA_BIT_LAST = 3'h7;
	// reset value of the count register inside the baud module
	localparam logic [15:0] BAUD_CNT_RESET = 16'h0001;
	// address match schemes
	localparam logic [1:0] SCHEME_ALL = 2'h0;
	localparam logic [1:0] SCHEME_ADDR = 2'h1;
	localparam logic [1:0] SCHEME_MATCH = 2'h2;
	localparam logic [1:0] SCHEME_MATCH_DATA = 2'h3;

	// transmitter states
	typedef enum logic [7:0] {
		TX_IDLE = 8'h01,
		TX_SETUP = 8'h02,
		TX_GO = 8'h04,
		TX_START = 8'h08,
		TX_DATA = 8'h10,
		TX_NINTH = 8'h20,
		TX_STOP = 8'h40,
		TX_LAST = 8'h80
	} unfde_tx_state_e;

	// receiver states
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_NINTH = 5'h08,
		RX_STOP = 5'h10
	} unfde_rx_state_e;

	// configuration bits set by software
	typedef struct packed {
		logic transmit_enable;
		logic receive_enable;
		logic parity_enable;
		logic parity_odd;
		logic two_stop_bits;
		logic clear_to_send_enable;
		logic nine_bit_mode_enable;
		logic [1:0] address_match_scheme;
		logic [7:0] address_compare;
		logic driver_enable_polarity;
		logic rx_int_errors_only;
		logic tx_ninth_bit;
	} unfde_cfg_s;

	// receive status that belongs to the byte in the data register
	typedef struct packed {
		logic rx_data_available;
		logic rx_ninth_bit;
		logic first_data_of_frame;
		logic parity_error;
		logic framing_error;
	} unfde_rx_stat_s;
endpackage

// *** core/unfde_baud.sv ***
// Purpose: divider that makes the 16x bit-rate enable pulse
// Assumes: divisor of zero is treated as one
// Notes: tick is a one-cycle pulse every divisor clocks

`timescale 1ns/1ps

// ==========================================================
// baud tick divider
module unfde_baud (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// divisor
	input wire logic [15:0] baud_divisor,
	// enable pulse at sixteen times the bit rate
	output logic tick16
);
	logic [15:0] cnt_reg;

	// R26 divide by divisor
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= unfde_pkg::BAUD_CNT_RESET;
			tick16 <= 1'b0;
		end else if (cnt_reg <= 16'h0001) begin
			cnt_reg <= baud_divisor; // reload picks up divisor changes at a boundary
			tick16 <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
			tick16 <= 1'b0;
		end
	end
endmodule // unfde_baud

// *** core/unfde_core.sv ***
// Purpose: uart with cts flow control, nine-bit addressing and driver enable
// Assumes: single 50 MHz clock, pins synchronised here, host strobes are one-cycle pulses
// Notes: no overrun or break handling; a new byte overwrites the data register
// Function
// R1 - cts sampled one clock before each character
// R2 - remote drops cts a clock before start
// R3 - character in flight always finishes
// R4 - ninth bit after data, before stop
// R5 - ninth bit replaces parity in nine-bit mode
// R6 - ninth bit equals software ninth-bit control
// R7 - matching only with nine-bit mode enabled
// R8 - scheme 01 interrupts on addresses only
// R9 - scheme 00 or nine-bit mode off: every byte interrupts
// R10 - received ninth bit shown as status
// R11 - scheme 10 filters by address compare
// R12 - first data after match flags new frame
// R13 - every address compared again
// R14 - scheme 11 as 10 without address interrupts
// R15 - receive interrupt: data plus errors or errors
// R16 - transmit interrupt at once when empty
// R17 - written byte moves to shifter automatically
// R18 - data available flag mirrors unread byte
// R19 - driver enable one to two bits early
// R20 - driver enable drops one clock after stop
// R21 - driver enable held across back-to-back characters
// R22 - driver enable polarity selectable
// R23 - eight data bits lsb first, framed
// R24 - empty flag after first bit, cleared by write
// R25 - reading data clears data available
// R26 - bit rate is clock over sixteen divisor
// R27 - receiver samples mid bit, validates start

`timescale 1ns/1ps

// ==========================================================
// top
module unfde_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire unfde_pkg::unfde_cfg_s cfg,
	input wire logic [15:0] baud_divisor,
	// transmit data port
	input wire logic tx_data_wr,
	input wire logic [7:0] tx_data,
	output logic tx_holding_empty,
	output logic tx_irq,
	// receive data port
	input wire logic rx_data_rd,
	output logic [7:0] rx_data,
	output unfde_pkg::unfde_rx_stat_s rx_stat,
	output logic rx_irq,
	// serial pins
	input wire logic rxd,
	input wire logic clear_to_send_n,
	output logic txd,
	output logic driver_enable
);
	logic tick16;
	logic [2:0] rxd_sync_reg;
	logic [2:0] cts_sync_reg;
	logic rxd_filt_reg;
	logic cts_n_filt_reg;
	unfde_pkg::unfde_tx_state_e tx_state_reg;
	logic [3:0] tx_tick_reg;
	logic [2:0] tx_bit_reg;
	logic [4:0] setup_cnt_reg;
	logic [7:0] tx_shift_reg;
	logic tx_ninth_reg;
	logic tx_has_ninth_reg;
	logic tx_stop2_reg;
	logic tx_stop_second_reg;
	logic [7:0] hold_reg;
	logic hold_full_reg;
	logic tx_empty_reg;
	logic txd_reg;
	logic drv_en_reg;
	logic tx_bit_end;
	logic tx_cts_ok;
	logic tx_load;
	unfde_pkg::unfde_rx_state_e rx_state_reg;
	logic [3:0] rx_tick_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_ninth_in_reg;
	logic rx_done_reg;
	logic rx_stop_ok_reg;
	logic rx_matched_reg;
	logic rx_pending_reg;
	logic [7:0] rx_data_reg;
	unfde_pkg::unfde_rx_stat_s rx_stat_reg;
	logic rx_has_ninth;
	logic rx_is_addr;
	logic rx_auto;
	logic rx_deliver;
	logic rx_first_data;

	// parity bit that makes the count of ones even, inverted for odd
	function automatic logic unfde_parity(input logic [7:0] d, input logic odd);
		unfde_parity = (^d) ^ odd;
	endfunction

	// ==========================================================
	// bit-rate enable
	unfde_baud u_baud (
		.clk(clk),
		.rst_n(rst_n),
		.baud_divisor(baud_divisor),
		.tick16(tick16)
	);

	// ==========================================================
	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxd_sync_reg <= 3'h7;
			cts_sync_reg <= 3'h7;
			rxd_filt_reg <= 1'b1;
			cts_n_filt_reg <= 1'b1;
		end else begin
			rxd_sync_reg <= {rxd_sync_reg[1:0], rxd};
			cts_sync_reg <= {cts_sync_reg[1:0], clear_to_send_n};
			if (rxd_sync_reg[1] == rxd_sync_reg[2]) begin
				rxd_filt_reg <= rxd_sync_reg[2];
			end
			if (cts_sync_reg[1] == cts_sync_reg[2]) begin
				cts_n_filt_reg <= cts_sync_reg[2];
			end
		end
	end

	// ==========================================================
	// transmitter
	assign tx_bit_end = tick16 && (tx_tick_reg == unfde_pkg::TICK_LAST);
	// R1 cts gate
	assign tx_cts_ok = !cfg.clear_to_send_enable || !cts_n_filt_reg;
	assign tx_load = (tx_state_reg == unfde_pkg::TX_GO) && tx_cts_ok;

	// character sequencer; cts only looked at in the go state, so a frame in flight runs on
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_state_reg <= unfde_pkg::TX_IDLE;
			tx_tick_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			setup_cnt_reg <= 5'h00;
			tx_shift_reg <= 8'h00;
			tx_ninth_reg <= 1'b0;
			tx_has_ninth_reg <= 1'b0;
			tx_stop2_reg <= 1'b0;
			tx_stop_second_reg <= 1'b0;
		end else begin
			if (tick16) begin
				tx_tick_reg <= tx_tick_reg + 4'h1;
			end
			case (tx_state_reg)
				unfde_pkg::TX_IDLE: begin
					setup_cnt_reg <= 5'h00;
					if (cfg.transmit_enable && hold_full_reg) begin
						tx_state_reg <= unfde_pkg::TX_SETUP;
					end
				end
				// R19 setup time before start
				unfde_pkg::TX_SETUP: begin
					if (tick16) begin
						setup_cnt_reg <= setup_cnt_reg + 5'h01;
						if (setup_cnt_reg == unfde_pkg::DRV_SETUP_TICKS - 5'h01) begin
							tx_state_reg <= unfde_pkg::TX_GO;
						end
					end
				end
				// R17 load shifter from holding
				unfde_pkg::TX_GO: begin
					if (tx_cts_ok) begin
						tx_state_reg <= unfde_pkg::TX_START;
						tx_tick_reg <= 4'h0;
						tx_shift_reg <= hold_reg;
						// R5 ninth slot carries address flag
						// R6 ninth bit from software
						tx_ninth_reg <= cfg.nine_bit_mode_enable ? cfg.tx_ninth_bit :
							unfde_parity(hold_reg, cfg.parity_odd);
						tx_has_ninth_reg <= cfg.nine_bit_mode_enable || cfg.parity_enable;
						tx_stop2_reg <= cfg.two_stop_bits;
						tx_stop_second_reg <= 1'b0;
					end
				end
				// R3 no cts check once started
				unfde_pkg::TX_START: begin
					if (tx_bit_end) begin
						tx_state_reg <= unfde_pkg::TX_DATA;
						tx_bit_reg <= 3'h0;
					end
				end
				// R23 eight data bits lsb first
				unfde_pkg::TX_DATA: begin
					if (tx_bit_end) begin
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == unfde_pkg::DATA_BIT_LAST) begin
							// R4 ninth bit right after data
							tx_state_reg <= tx_has_ninth_reg ? unfde_pkg::TX_NINTH : unfde_pkg::TX_STOP;
						end
					end
				end
				unfde_pkg::TX_NINTH: begin
					if (tx_bit_end) begin
						tx_state_reg <= unfde_pkg::TX_STOP;
					end
				end
				unfde_pkg::TX_STOP: begin
					if (tx_bit_end) begin
						if (tx_stop2_reg && !tx_stop_second_reg) begin
							tx_stop_second_reg <= 1'b1;
						end else begin
							tx_state_reg <= unfde_pkg::TX_LAST;
						end
					end
				end
				// R21 next byte waiting keeps the driver on
				unfde_pkg::TX_LAST: begin
					if (cfg.transmit_enable && hold_full_reg) begin
						tx_state_reg <= unfde_pkg::TX_GO;
					end else begin
						tx_state_reg <= unfde_pkg::TX_IDLE;
					end
				end
				default: begin
					tx_state_reg <= unfde_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// R17 holding register filled by writes, emptied by the load
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_reg <= 8'h00;
			hold_full_reg <= 1'b0;
		end else if (tx_data_wr) begin
			hold_reg <= tx_data;
			hold_full_reg <= 1'b1;
		end else if (tx_load) begin
			hold_full_reg <= 1'b0;
		end
	end

	// R24 empty flag: set after start bit, write clears it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_empty_reg <= 1'b1;
		end else if (tx_data_wr) begin
			tx_empty_reg <= 1'b0;
		end else if ((tx_state_reg == unfde_pkg::TX_START) && tx_bit_end && !hold_full_reg) begin
			tx_empty_reg <= 1'b1;
		end
	end

	// line and driver enable registered together so they stay aligned
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txd_reg <= 1'b1;
			drv_en_reg <= 1'b0;
		end else begin
			case (tx_state_reg)
				unfde_pkg::TX_START: txd_reg <= 1'b0;
				unfde_pkg::TX_DATA: txd_reg <= tx_shift_reg[tx_bit_reg];
				unfde_pkg::TX_NINTH: txd_reg <= tx_ninth_reg;
				default: txd_reg <= 1'b1;
			endcase
			// R20 on through stop, off one clock after
			drv_en_reg <= (tx_state_reg != unfde_pkg::TX_IDLE);
		end
	end

	assign txd = txd_reg;
	// R22 polarity select
	assign driver_enable = drv_en_reg ^ cfg.driver_enable_polarity;
	assign tx_holding_empty = tx_empty_reg;
	// R16 request as soon as enabled and empty
	assign tx_irq = cfg.transmit_enable && tx_empty_reg;

	// ==========================================================
	// receiver
	assign rx_has_ninth = cfg.nine_bit_mode_enable || cfg.parity_enable;

	// R27 start check at mid bit, then sample every sixteen ticks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_state_reg <= unfde_pkg::RX_IDLE;
			rx_tick_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_ninth_in_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			rx_stop_ok_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			if (tick16) begin
				rx_tick_reg <= rx_tick_reg + 4'h1;
			end
			case (rx_state_reg)
				unfde_pkg::RX_IDLE: begin
					rx_tick_reg <= 4'h0;
					if (cfg.receive_enable && !rxd_filt_reg) begin
						rx_state_reg <= unfde_pkg::RX_START;
					end
				end
				unfde_pkg::RX_START: begin
					if (tick16 && rx_tick_reg == unfde_pkg::RX_MID_TICK) begin
						rx_tick_reg <= 4'h0;
						rx_bit_reg <= 3'h0;
						// a glitch shorter than half a bit is dropped
						rx_state_reg <= rxd_filt_reg ? unfde_pkg::RX_IDLE : unfde_pkg::RX_DATA;
					end
				end
				unfde_pkg::RX_DATA: begin
					if (tick16 && rx_tick_reg == unfde_pkg::TICK_LAST) begin
						rx_shift_reg[rx_bit_reg] <= rxd_filt_reg;
						rx_bit_reg <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == unfde_pkg::DATA_BIT_LAST) begin
							rx_state_reg <= rx_has_ninth ? unfde_pkg::RX_NINTH : unfde_pkg::RX_STOP;
						end
					end
				end
				unfde_pkg::RX_NINTH: begin
					if (tick16 && rx_tick_reg == unfde_pkg::TICK_LAST) begin
						rx_ninth_in_reg <= rxd_filt_reg;
						rx_state_reg <= unfde_pkg::RX_STOP;
					end
				end
				// second stop bit is not checked; idle at mid stop re-arms early
				unfde_pkg::RX_STOP: begin
					if (tick16 && rx_tick_reg == unfde_pkg::TICK_LAST) begin
						rx_stop_ok_reg <= rxd_filt_reg;
						rx_done_reg <= 1'b1;
						rx_state_reg <= unfde_pkg::RX_IDLE;
						if (!rx_has_ninth) begin
							rx_ninth_in_reg <= 1'b0;
						end
					end
				end
				default: begin
					rx_state_reg <= unfde_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// R7 schemes act only in nine-bit mode
	assign rx_is_addr = cfg.nine_bit_mode_enable && rx_ninth_in_reg;
	assign rx_auto = cfg.nine_bit_mode_enable && cfg.address_match_scheme[1];

	// which finished bytes reach the data register
	always_comb begin
		rx_deliver = 1'b0;
		rx_first_data = 1'b0;
		if (rx_done_reg) begin
			if (!cfg.nine_bit_mode_enable || cfg.address_match_scheme == unfde_pkg::SCHEME_ALL) begin
				// R9 every byte reported
				rx_deliver = 1'b1;
			end else if (cfg.address_match_scheme == unfde_pkg::SCHEME_ADDR) begin
				// R8 addresses only
				rx_deliver = rx_is_addr;
			end else if (rx_is_addr) begin
				// R11 compare address
				// R14 no address report in scheme 11
				rx_deliver = (rx_shift_reg == cfg.address_compare) &&
					(cfg.address_match_scheme == unfde_pkg::SCHEME_MATCH);
			end else begin
				rx_deliver = rx_matched_reg;
				// R12 first data after match
				rx_first_data = rx_pending_reg;
			end
		end
	end

	// R13 each address re-arms or blocks the frame
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_matched_reg <= 1'b0;
			rx_pending_reg <= 1'b0;
		end else if (!rx_auto) begin
			rx_matched_reg <= 1'b0;
			rx_pending_reg <= 1'b0;
		end else if (rx_done_reg && rx_is_addr) begin
			rx_matched_reg <= (rx_shift_reg == cfg.address_compare);
			rx_pending_reg <= (rx_shift_reg == cfg.address_compare);
		end else if (rx_deliver) begin
			rx_pending_reg <= 1'b0;
		end
	end

	// R18 data register and status; a new byte wins over a read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_data_reg <= 8'h00;
			rx_stat_reg <= '0;
		end else if (rx_deliver) begin
			rx_data_reg <= rx_shift_reg;
			rx_stat_reg.rx_data_available <= 1'b1;
			// R10 ninth bit visible
			rx_stat_reg.rx_ninth_bit <= rx_is_addr;
			rx_stat_reg.first_data_of_frame <= rx_first_data;
			rx_stat_reg.parity_error <= cfg.parity_enable && !cfg.nine_bit_mode_enable &&
				(rx_ninth_in_reg != unfde_parity(rx_shift_reg, cfg.parity_odd));
			rx_stat_reg.framing_error <= !rx_stop_ok_reg;
		end else if (rx_data_rd) begin
			// R25 read empties the register
			rx_stat_reg.rx_data_available <= 1'b0;
			rx_stat_reg.first_data_of_frame <= 1'b0;
			rx_stat_reg.parity_error <= 1'b0;
			rx_stat_reg.framing_error <= 1'b0;
		end
	end

	assign rx_data = rx_data_reg;
	assign rx_stat = rx_stat_reg;
	// R15 data plus errors, or errors only
	assign rx_irq = (rx_stat_reg.rx_data_available && !cfg.rx_int_errors_only) ||
		rx_stat_reg.parity_error || rx_stat_reg.framing_error;

	// ==========================================================
	// checks
	default clocking chk_clk @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [21:0] chk_setup_clks_reg;
	logic [21:0] chk_div_eff;
	assign chk_div_eff = (baud_divisor == 16'h0000) ? 22'h000001 : {6'h00, baud_divisor};
	// clocks spent in setup, read only by the checks
	always_ff @(posedge clk) begin
		if (!rst_n || tx_state_reg != unfde_pkg::TX_SETUP) begin
			chk_setup_clks_reg <= 22'h000000;
		end else begin
			chk_setup_clks_reg <= chk_setup_clks_reg + 22'h000001;
		end
	end

	chk_cts_gate: assert property ($rose(tx_state_reg == unfde_pkg::TX_START) |-> $past(tx_cts_ok)) // R1
		else $error("character started while cts deasserted");
	chk_frame_runs: assert property ((tx_state_reg == unfde_pkg::TX_DATA) && !tx_bit_end |=> // R3
		tx_state_reg == unfde_pkg::TX_DATA || tx_state_reg == unfde_pkg::TX_NINTH ||
		tx_state_reg == unfde_pkg::TX_STOP)
		else $error("character aborted mid frame");
	chk_ninth_line: assert property ((tx_state_reg == unfde_pkg::TX_NINTH) |=> txd == tx_ninth_reg) // R4
		else $error("ninth bit slot carries wrong level");
	chk_ninth_value: assert property (tx_load && cfg.nine_bit_mode_enable |=> tx_ninth_reg == $past(cfg.tx_ninth_bit)) // R6
		else $error("ninth bit not taken from software control");
	chk_drv_setup: assert property ($fell(tx_state_reg == unfde_pkg::TX_SETUP) |-> // R19
		($past(chk_setup_clks_reg) + 22'h000001 >= (chk_div_eff << 4)) &&
		($past(chk_setup_clks_reg) < (chk_div_eff << 5)))
		else $error("driver enable setup outside one to two bits");
	chk_drv_drop: assert property ((tx_state_reg == unfde_pkg::TX_LAST) ##1 (tx_state_reg == unfde_pkg::TX_IDLE) // R20
		|-> drv_en_reg ##1 !drv_en_reg)
		else $error("driver enable not dropped one clock after stop");
	chk_drv_frame: assert property ((tx_state_reg == unfde_pkg::TX_STOP) |=> drv_en_reg) // R20
		else $error("driver enable low during frame");
	chk_empty_clear: assert property (tx_data_wr |=> !tx_holding_empty) // R24
		else $error("write did not clear empty flag");
	chk_empty_set: assert property ((tx_state_reg == unfde_pkg::TX_START) && tx_bit_end && !hold_full_reg && // R24
		!tx_data_wr |=> tx_holding_empty ##0 tx_state_reg == unfde_pkg::TX_DATA)
		else $error("empty flag not set after start bit");
	chk_read_clears: assert property (rx_data_rd && !rx_deliver |=> !rx_stat.rx_data_available) // R25
		else $error("read left data available set");
	chk_scheme_addr: assert property (rx_deliver && cfg.nine_bit_mode_enable && // R8
		cfg.address_match_scheme == unfde_pkg::SCHEME_ADDR |=> rx_stat.rx_ninth_bit)
		else $error("data byte reported in address scheme");
	chk_scheme_mute: assert property (rx_done_reg && rx_is_addr && // R14
		cfg.address_match_scheme == unfde_pkg::SCHEME_MATCH_DATA |=> $stable(rx_data))
		else $error("address reported in scheme 11");
	chk_newframe: assert property (rx_deliver && rx_first_data |=> rx_stat.first_data_of_frame && !rx_stat.rx_ninth_bit) // R12
		else $error("new frame flag on wrong byte");

	cov_back_to_back: cover property ((tx_state_reg == unfde_pkg::TX_LAST) ##1 (tx_state_reg == unfde_pkg::TX_GO));
	cov_cts_hold: cover property ((tx_state_reg == unfde_pkg::TX_GO) && !tx_cts_ok);
	cov_match_frame: cover property (rx_deliver && rx_first_data);
	cov_parity_err: cover property (rx_deliver && cfg.parity_enable && !cfg.nine_bit_mode_enable);
endmodule // unfde_core

// *** verification/unfde_remote.sv ***
// Purpose: remote node on the shared serial line
// Assumes: bit time of BIT_CLKS system clocks
// Notes: line idles high between frames, as on a biased bus
`timescale 1ns/1ps
// ==========================================================
// remote node
module unfde_remote #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input wire logic clk,
	// serial pins
	output logic rxd,
	output logic clear_to_send_n
);
	// idle line, sending allowed
	initial begin
		rxd = 1'b1;
		clear_to_send_n = 1'b0;
	end
	// pause before start
	// the bench calls this between characters and also mid frame
	task automatic pause(input logic hold);
		@(posedge clk);
		clear_to_send_n <= hold;
	endtask
	// frame lsb first
	// start, eight data, ninth bit, one stop
	task automatic send(input logic [7:0] d, input logic nb);
		logic [10:0] f;
		f = {1'b1, nb, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
	endtask
endmodule // unfde_remote

// *** verification/uart_nine_bit_flow_driver_enable_tb.sv ***
// Purpose: self-checking bench of the nine-bit uart core
// Assumes: divisor 1, so one bit is 16 clocks
// Notes: samples 1 ns after the edge so design updates have landed
`timescale 1ns/1ps
// ==========================================================
// bench
module uart_nine_bit_flow_driver_enable_tb;
	logic clk, rst_n, tx_data_wr, tx_holding_empty, tx_irq, rx_data_rd, rx_irq;
	logic rxd, cts_n, txd, driver_enable;
	logic [15:0] baud_divisor;
	logic [7:0] tx_data, rx_data;
	unfde_pkg::unfde_cfg_s cfg;
	unfde_pkg::unfde_rx_stat_s rx_stat;
	int err_total = 0;
	int n_tests = 0;
	unfde_core dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .baud_divisor(baud_divisor), .tx_data_wr(tx_data_wr),
		.tx_data(tx_data), .tx_holding_empty(tx_holding_empty), .tx_irq(tx_irq), .rx_data_rd(rx_data_rd),
		.rx_data(rx_data), .rx_stat(rx_stat), .rx_irq(rx_irq), .rxd(rxd), .clear_to_send_n(cts_n), .txd(txd),
		.driver_enable(driver_enable));
	unfde_remote #(.BIT_CLKS(16)) remote (.clk(clk), .rxd(rxd), .clear_to_send_n(cts_n));
	// 50 MHz clock
	always #10 clk = ~clk;
	task automatic give_verdict();
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// one transmitted frame, setup time and driver enable envelope
	task automatic tx_frame(input logic [7:0] d, input logic nb);
		logic [9:0] f;
		int n;
		int k;
		f = {1'b1, nb, d};
		k = 0;
		@(posedge clk);
		cfg.tx_ninth_bit <= nb;
		tx_data <= d;
		tx_data_wr <= 1'b1;
		@(posedge clk);
		tx_data_wr <= 1'b0;
		#1;
		chk(tx_holding_empty === 1'b0, "not empty after write");
		for (n = 0; n < 100 && txd === 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (driver_enable === 1'b1)
				k++;
		end
		if (n == 100) begin
			chk(1'b0, "no start bit");
			give_verdict();
		end
		chk(k >= 17 && k <= 33, "driver enable setup");
		repeat (8) @(posedge clk);
		#1;
		chk(txd === 1'b0, "start bit");
		for (int i = 0; i < 10; i++) begin
			repeat (16) @(posedge clk);
			#1;
			chk(txd === f[i] && driver_enable === 1'b1, "frame bit");
			if (i == 0)
				chk(tx_holding_empty === 1'b1 && tx_irq === 1'b1, "empty after first bit");
		end
		repeat (8) @(posedge clk);
		#1;
		chk(driver_enable === 1'b1, "enable through stop");
		@(posedge clk);
		#1;
		chk(driver_enable === 1'b0, "enable drop");
	endtask
	// next byte written mid frame keeps the driver on across both characters
	task automatic tx_pair();
		int n;
		@(posedge clk);
		tx_data <= 8'h81;
		tx_data_wr <= 1'b1;
		@(posedge clk);
		tx_data_wr <= 1'b0;
		#1;
		for (n = 0; n < 100 && tx_holding_empty !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(n < 100, "no room for second byte");
		@(posedge clk);
		tx_data <= 8'h7e;
		tx_data_wr <= 1'b1;
		@(posedge clk);
		tx_data_wr <= 1'b0;
		#1;
		// rest of the first frame, the two-clock gap, the whole second frame, then one clock of tail
		for (n = 0; n < 500 && driver_enable === 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(n == 338, "driver enable gap between characters");
	endtask
	// character held while clear to send is off
	task automatic cts_hold();
		int n;
		remote.pause(1'b1);
		cfg.clear_to_send_enable <= 1'b1;
		tx_data <= 8'h0f;
		tx_data_wr <= 1'b1;
		@(posedge clk);
		tx_data_wr <= 1'b0;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			#1;
			if (txd !== 1'b1)
				break;
		end
		chk(n == 100, "start while held");
		remote.pause(1'b0);
		for (n = 0; n < 12 && txd === 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(txd === 1'b0, "no start on release");
		// cts dropped mid frame must not cut the character
		remote.pause(1'b1);
		#1;
		for (n = 0; n < 300 && driver_enable === 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(n == 176, "character cut by cts");
		remote.pause(1'b0);
		cfg.clear_to_send_enable <= 1'b0;
	endtask
	// one received frame, delivery and status, then read
	task automatic rx_byte(input logic [7:0] d, input logic nb, input logic dlv, input logic first);
		logic pe;
		remote.send(d, nb);
		pe = cfg.parity_enable && !cfg.nine_bit_mode_enable && (nb != ((^d) ^ cfg.parity_odd));
		repeat (4) @(posedge clk);
		#1;
		chk(rx_stat.rx_data_available === dlv, "delivery");
		if (dlv) begin
			chk(rx_data === d && rx_stat.rx_ninth_bit === (nb & cfg.nine_bit_mode_enable), "rx byte");
			chk(!cfg.address_match_scheme[1] || rx_stat.first_data_of_frame === first, "new frame");
			chk(rx_irq === (~cfg.rx_int_errors_only | pe) && rx_stat.parity_error === pe, "rx irq");
			@(posedge clk);
			rx_data_rd <= 1'b1;
			@(posedge clk);
			rx_data_rd <= 1'b0;
			#1;
			chk(rx_stat.rx_data_available === 1'b0, "read clears");
		end
		@(posedge clk);
	endtask
	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		cfg = '0;
		cfg.transmit_enable = 1'b1;
		cfg.receive_enable = 1'b1;
		cfg.nine_bit_mode_enable = 1'b1;
		cfg.address_compare = 8'h5a;
		baud_divisor = 16'h0001;
		tx_data_wr = 1'b0;
		tx_data = 8'h00;
		rx_data_rd = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(tx_irq === 1'b1 && driver_enable === 1'b0, "irq at once");
		tx_frame(8'ha5, 1'b1);
		tx_frame(8'h3c, 1'b0);
		tx_pair();
		@(posedge clk);
		cfg.driver_enable_polarity <= 1'b1;
		@(posedge clk);
		#1;
		chk(driver_enable === 1'b1, "polarity");
		@(posedge clk);
		cfg.driver_enable_polarity <= 1'b0;
		cts_hold();
		rx_byte(8'h11, 1'b0, 1'b1, 1'b0);
		cfg.address_match_scheme <= 2'h1;
		rx_byte(8'h22, 1'b0, 1'b0, 1'b0);
		rx_byte(8'h33, 1'b1, 1'b1, 1'b0);
		cfg.address_match_scheme <= 2'h2;
		rx_byte(8'h44, 1'b1, 1'b0, 1'b0);
		rx_byte(8'h55, 1'b0, 1'b0, 1'b0);
		rx_byte(8'h5a, 1'b1, 1'b1, 1'b0);
		rx_byte(8'h66, 1'b0, 1'b1, 1'b1);
		rx_byte(8'h77, 1'b0, 1'b1, 1'b0);
		rx_byte(8'h44, 1'b1, 1'b0, 1'b0);
		rx_byte(8'h88, 1'b0, 1'b0, 1'b0);
		cfg.address_match_scheme <= 2'h3;
		rx_byte(8'h5a, 1'b1, 1'b0, 1'b0);
		rx_byte(8'h99, 1'b0, 1'b1, 1'b1);
		cfg.nine_bit_mode_enable <= 1'b0;
		cfg.address_match_scheme <= 2'h1;
		rx_byte(8'h12, 1'b1, 1'b1, 1'b0);
		cfg.rx_int_errors_only <= 1'b1;
		rx_byte(8'hc3, 1'b1, 1'b1, 1'b0);
		cfg.parity_enable <= 1'b1;
		rx_byte(8'h01, 1'b0, 1'b1, 1'b0);
		give_verdict();
	end
endmodule // uart_nine_bit_flow_driver_enable_tb
